// >>> rtl/gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH
// register indices; byte address is four times the index
`define IDX_PORT_A_LATCH   8'h00
`define IDX_PORT_B_LATCH   8'h01
`define IDX_PORT_D_LATCH   8'h03
`define IDX_PORT_A_DIR     8'h04
`define IDX_PORT_B_DIR     8'h05
`define IDX_PORT_D_DIR     8'h07
`define IDX_PORT_A_PUE     8'h0D
`define IDX_PIN_CONFIG     8'h10
// pin configuration register fields
`define CFG_OSC_GPIO_BIT   0
`define CFG_RC_OSC_BIT     1
`define CFG_TWOWIRE_D_BIT  2
// reset values
`define DIR_RESET          8'h00
`define PUE_RESET          8'h00
`define CFG_RESET          8'h00
`endif

// >>> rtl/gpio_port_pkg.sv
package gpio_port_pkg;
  typedef logic [7:0] port_t;
  typedef logic [4:0] chan_t;
endpackage

// >>> rtl/bidirectional_port_set.sv
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "gpio_port_regs.svh"
// How it works
// RL1: port A direction one enables driver
// RL2: reset clears port A direction bits
// RL3: port A read: latch if output, else pin
// RL4: latch writes always land; input reads show pin
// RL5: pull-up only while direction is input
// RL6: pull-up enable zero keeps pull-up off
// RL7: oscillator pin select chooses gpio or clock
// RL8: reset leaves port B and D latches alone
// RL9: reset clears port B direction bits
// RL10: port B read: latch if output, else pin
// RL11: serial enable overrides port D bits 6, 7
// RL12: timer select claims port D bits 4, 5
// RL13: channel select routes pin to converter
// RL14: software writes latch before driving pin
// RL15: small package: port A bit 7 output; here bit 7 follows its direction bit
// RL16: option bit gives two-wire unit port D 6, 7
// RL17: port D read: latch if output, else pin
// RL18: reset clears port D direction bits
// RL19: registers read back, update at access edge
module bidirectional_port_set (
  input  wire logic                 pclk,              // bus clock, 25 MHz
  input  wire logic                 presetn,           // async reset, active low
  input  wire logic                 psel,              // apb select
  input  wire logic                 penable,           // apb access phase
  input  wire logic                 pwrite,            // apb direction
  input  wire logic [11:0]          paddr,             // apb byte address
  input  wire logic [31:0]          pwdata,            // apb write data
  output logic      [31:0]          prdata,            // apb read data
  output logic                      pready,            // apb ready
  output logic                      pslverr,           // apb error
  input  wire gpio_port_pkg::port_t port_a_in,         // port A pin levels
  output gpio_port_pkg::port_t      port_a_out,        // port A pin drive value
  output gpio_port_pkg::port_t      port_a_oe,         // port A driver enable
  output gpio_port_pkg::port_t      port_a_pullup,     // port A pull-up connect
  output logic                      rc_clock_output_en, // osc pin carries rc clock
  input  wire gpio_port_pkg::port_t port_b_in,         // port B pin levels
  output gpio_port_pkg::port_t      port_b_out,        // port B pin drive value
  output gpio_port_pkg::port_t      port_b_oe,         // port B driver enable
  input  wire gpio_port_pkg::port_t port_d_in,         // port D pin levels
  output gpio_port_pkg::port_t      port_d_out,        // port D pin drive value
  output gpio_port_pkg::port_t      port_d_oe,         // port D driver enable
  input  wire logic                 serial_iface_enable, // serial unit owns D6/D7
  input  wire logic                 serial_tx_data,    // serial transmit bit
  output logic                      serial_rx_data,    // serial receive bit
  input  wire logic                 twowire_enable,    // two-wire unit enabled
  input  wire logic                 twowire_scl_oe,    // two-wire clock pulls low
  input  wire logic                 twowire_sda_oe,    // two-wire data pulls low
  output logic                      twowire_scl_in,    // two-wire clock level
  output logic                      twowire_sda_in,    // two-wire data level
  input  wire logic [1:0]           timer_ch_active,   // timer channel 0/1 in use
  input  wire logic [1:0]           timer_ch_out,      // timer compare outputs
  input  wire logic [1:0]           timer_ch_oe,       // timer channel drives pin
  output logic      [1:0]           timer_ch_in,       // timer capture levels
  input  wire gpio_port_pkg::chan_t converter_channel_select, // converter channel
  output logic                      converter_in_valid, // channel maps to a pin
  output logic                      converter_pin_level // selected pin level
);
  import gpio_port_pkg::*;

  port_t      a_lat_q, a_lat_d, b_lat_q, b_lat_d, d_lat_q, d_lat_d;
  port_t      a_dir_q, a_dir_d, b_dir_q, b_dir_d, d_dir_q, d_dir_d;
  port_t      a_pue_q, a_pue_d;
  logic [7:0] cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        wr_en, rd_en, hit;
  logic [9:0]  idx;
  logic        osc_gpio;

  assign idx   = paddr[11:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // register writes land on the access edge, latches regardless of direction
  always_comb begin
    a_lat_d = a_lat_q;
    b_lat_d = b_lat_q;
    d_lat_d = d_lat_q;
    a_dir_d = a_dir_q;
    b_dir_d = b_dir_q;
    d_dir_d = d_dir_q;
    a_pue_d = a_pue_q;
    cfg_d   = cfg_q;
    if (wr_en) begin
      case (idx)
        10'(`IDX_PORT_A_LATCH): a_lat_d = pwdata[7:0]; // see RL4
        10'(`IDX_PORT_B_LATCH): b_lat_d = pwdata[7:0]; // see RL4
        10'(`IDX_PORT_D_LATCH): d_lat_d = pwdata[7:0]; // see RL4
        10'(`IDX_PORT_A_DIR):   a_dir_d = pwdata[7:0]; // see RL19
        10'(`IDX_PORT_B_DIR):   b_dir_d = pwdata[7:0]; // see RL19
        10'(`IDX_PORT_D_DIR):   d_dir_d = pwdata[7:0]; // see RL19
        10'(`IDX_PORT_A_PUE):   a_pue_d = pwdata[7:0]; // see RL19
        10'(`IDX_PIN_CONFIG):   cfg_d   = {5'h00, pwdata[2:0]};
        default: ;
      endcase
    end
  end

  // latches have no reset: their content survives a reset
  always_ff @(posedge pclk) begin
    a_lat_q <= a_lat_d;
    b_lat_q <= b_lat_d; // see RL8
    d_lat_q <= d_lat_d; // see RL8
  end

  // direction and control registers start as inputs, pull-ups off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_dir_q <= `DIR_RESET; // see RL2
      b_dir_q <= `DIR_RESET; // see RL9
      d_dir_q <= `DIR_RESET; // see RL18
      a_pue_q <= `PUE_RESET;
      cfg_q   <= `CFG_RESET;
    end else begin
      a_dir_q <= a_dir_d;
      b_dir_q <= b_dir_d;
      d_dir_q <= d_dir_d;
      a_pue_q <= a_pue_d;
      cfg_q   <= cfg_d;
    end
  end

  // read mux: output bits show the latch, input bits the pin
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    hit     = 1'b1;
    if (rd_en) begin
      rdata_d = 32'h0000_0000;
      case (idx)
        10'(`IDX_PORT_A_LATCH):
          rdata_d[7:0] = (a_dir_q & a_lat_q) | (~a_dir_q & port_a_in); // see RL3
        10'(`IDX_PORT_B_LATCH):
          rdata_d[7:0] = (b_dir_q & b_lat_q) | (~b_dir_q & port_b_in); // see RL10
        10'(`IDX_PORT_D_LATCH):
          rdata_d[7:0] = (d_dir_q & d_lat_q) | (~d_dir_q & port_d_in); // see RL17
        10'(`IDX_PORT_A_DIR):   rdata_d[7:0] = a_dir_q; // see RL19
        10'(`IDX_PORT_B_DIR):   rdata_d[7:0] = b_dir_q;
        10'(`IDX_PORT_D_DIR):   rdata_d[7:0] = d_dir_q;
        10'(`IDX_PORT_A_PUE):   rdata_d[7:0] = a_pue_q; // see RL19
        10'(`IDX_PIN_CONFIG):   rdata_d[7:0] = cfg_q;
        default:                hit = 1'b0;
      endcase
      err_d = !hit;
    end else if (psel && !penable) begin
      err_d = !(idx inside {10'(`IDX_PORT_A_LATCH), 10'(`IDX_PORT_B_LATCH),
                            10'(`IDX_PORT_D_LATCH), 10'(`IDX_PORT_A_DIR),
                            10'(`IDX_PORT_B_DIR), 10'(`IDX_PORT_D_DIR),
                            10'(`IDX_PORT_A_PUE), 10'(`IDX_PIN_CONFIG)});
    end
  end

  // pin is sampled in the setup cycle so the data is stable for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = psel && penable && err_q;

  // port A: osc pin bit 6 is gpio only in rc mode with the select set
  assign osc_gpio = !cfg_q[`CFG_RC_OSC_BIT] || cfg_q[`CFG_OSC_GPIO_BIT]; // see RL7
  assign rc_clock_output_en = cfg_q[`CFG_RC_OSC_BIT] && !cfg_q[`CFG_OSC_GPIO_BIT]; // see RL7
  assign port_a_out = a_lat_q;

  // per-bit driver and pull-up for port A; in crystal mode the pin is oscillator-owned
  for (genvar i = 0; i < 8; i++) begin : g_pa
    if (i == 6) begin : g_osc
      assign port_a_oe[i]     = a_dir_q[i] && osc_gpio && cfg_q[`CFG_RC_OSC_BIT]; // see RL1
      assign port_a_pullup[i] = a_pue_q[i] && !a_dir_q[i] && osc_gpio
                                && cfg_q[`CFG_RC_OSC_BIT]; // see RL5
    end else begin : g_std
      assign port_a_oe[i]     = a_dir_q[i]; // see RL1
      assign port_a_pullup[i] = a_pue_q[i] && !a_dir_q[i]; // see RL5 see RL6
    end
  end

  // port B is plain gpio; converter reads the pad directly
  assign port_b_out = b_lat_q;
  assign port_b_oe  = b_dir_q; // see RL9

  // port D overrides: serial beats two-wire beats gpio on D6/D7; timer on D4/D5
  logic tw_on_d;
  assign tw_on_d = twowire_enable && cfg_q[`CFG_TWOWIRE_D_BIT] && !serial_iface_enable; // see RL16
  always_comb begin
    port_d_out = d_lat_q;
    port_d_oe  = d_dir_q;
    for (int t = 0; t < 2; t++) begin
      if (timer_ch_active[t]) begin
        port_d_out[4+t] = timer_ch_out[t]; // see RL12
        port_d_oe[4+t]  = timer_ch_oe[t]; // see RL12
      end
    end
    if (serial_iface_enable) begin
      port_d_out[6] = serial_tx_data; // see RL11
      port_d_oe[6]  = 1'b1; // see RL11
      port_d_out[7] = 1'b0;
      port_d_oe[7]  = 1'b0; // see RL11
    end else if (tw_on_d) begin
      port_d_out[6] = 1'b0;
      port_d_oe[6]  = twowire_scl_oe; // see RL16
      port_d_out[7] = 1'b0;
      port_d_oe[7]  = twowire_sda_oe; // see RL16
    end
  end

  assign serial_rx_data = port_d_in[7];
  assign twowire_scl_in = tw_on_d ? port_d_in[6] : 1'b1;
  assign twowire_sda_in = tw_on_d ? port_d_in[7] : 1'b1;
  assign timer_ch_in    = port_d_in[5:4];

  // converter channels 0-7 on port B, 8-11 on port D bits 3 down to 0
  always_comb begin
    converter_in_valid  = 1'b1;
    converter_pin_level = 1'b0;
    if (converter_channel_select < 5'h08)
      converter_pin_level = port_b_in[converter_channel_select[2:0]]; // see RL13
    else if (converter_channel_select < 5'h0C)
      converter_pin_level = port_d_in[3 - converter_channel_select[1:0]]; // see RL13
    else
      converter_in_valid = 1'b0;
  end

  // assertions
  a_dir_oe_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
    wr_en && idx == 10'(`IDX_PORT_A_DIR) |=> port_a_oe[0] == $past(pwdata[0]))
    else $error("port A driver does not follow direction write");
  a_pull_off: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
    (port_a_pullup & a_dir_q) == 8'h00)
    else $error("pull-up connected on an output bit");
  a_pull_gate: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
    (port_a_pullup & ~a_pue_q) == 8'h00)
    else $error("pull-up connected while disabled");
  a_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL3
    rd_en && idx == 10'(`IDX_PORT_A_LATCH) |=>
      prdata[7:0] == (($past(a_dir_q) & $past(a_lat_q)) | (~$past(a_dir_q) & $past(port_a_in))))
    else $error("port A read mux wrong");
  a_latch_wr: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
    wr_en && idx == 10'(`IDX_PORT_B_LATCH) |=> b_lat_q == $past(pwdata[7:0]))
    else $error("port B latch not written");
  a_serial_own: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
    serial_iface_enable |-> port_d_oe[7:6] == 2'b01 && port_d_out[6] == serial_tx_data)
    else $error("serial does not own port D 6/7");
  a_timer_own: assert property (@(posedge pclk) disable iff (!presetn) // see RL12
    timer_ch_active[0] |-> port_d_oe[4] == timer_ch_oe[0])
    else $error("timer does not own port D 4");
  a_pue_rb: assert property (@(posedge pclk) disable iff (!presetn) // see RL19
    rd_en && idx == 10'(`IDX_PORT_A_PUE) |=> prdata[7:0] == $past(a_pue_q))
    else $error("pull-up register read-back wrong");

  // reset state: checked at the first edge after release, while reset cannot mask it
  a_rst_dir_a: assert property (@(posedge pclk) // see RL2
    $rose(presetn) |-> a_dir_q == 8'h00)
    else $error("port A direction not cleared by reset");
  a_rst_dir_b: assert property (@(posedge pclk) // see RL9
    $rose(presetn) |-> b_dir_q == 8'h00)
    else $error("port B direction not cleared by reset");
  a_rst_dir_d: assert property (@(posedge pclk) // see RL18
    $rose(presetn) |-> d_dir_q == 8'h00)
    else $error("port D direction not cleared by reset");

  // read muxes of ports B and D, data captured in the setup cycle
  a_read_b: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
    rd_en && idx == 10'(`IDX_PORT_B_LATCH) |=>
      prdata[7:0] == (($past(b_dir_q) & $past(b_lat_q)) | (~$past(b_dir_q) & $past(port_b_in))))
    else $error("port B read mux wrong");
  a_read_d: assert property (@(posedge pclk) disable iff (!presetn) // see RL17
    rd_en && idx == 10'(`IDX_PORT_D_LATCH) |=>
      prdata[7:0] == (($past(d_dir_q) & $past(d_lat_q)) | (~$past(d_dir_q) & $past(port_d_in))))
    else $error("port D read mux wrong");

  // writes land on the access edge
  a_lat_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
    wr_en && idx == 10'(`IDX_PORT_A_LATCH) |=> a_lat_q == $past(pwdata[7:0]))
    else $error("port A latch not written");
  a_dir_wr_b: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
    wr_en && idx == 10'(`IDX_PORT_B_DIR) |=> port_b_oe == $past(pwdata[7:0]))
    else $error("port B driver does not follow direction write");
  a_dir_wr_d: assert property (@(posedge pclk) disable iff (!presetn) // see RL19
    wr_en && idx == 10'(`IDX_PORT_D_DIR) |=> d_dir_q == $past(pwdata[7:0]))
    else $error("port D direction not written");

  // oscillator pin ownership in both oscillator options
  a_osc_crystal_option: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    !cfg_q[`CFG_RC_OSC_BIT] |-> !port_a_oe[6] && !port_a_pullup[6] && !rc_clock_output_en)
    else $error("oscillator pin not held in crystal mode");
  a_osc_rc: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
    cfg_q[`CFG_RC_OSC_BIT] && !cfg_q[`CFG_OSC_GPIO_BIT] |-> rc_clock_output_en && !port_a_oe[6])
    else $error("rc clock not on oscillator pin");

  // shared-pin routing on port D and the converter
  a_twowire_own: assert property (@(posedge pclk) disable iff (!presetn) // see RL16
    twowire_enable && cfg_q[`CFG_TWOWIRE_D_BIT] && !serial_iface_enable |->
      port_d_oe[7:6] == {twowire_sda_oe, twowire_scl_oe} && port_d_out[7:6] == 2'b00)
    else $error("two-wire unit does not own port D 6/7");
  a_conv_map: assert property (@(posedge pclk) disable iff (!presetn) // see RL13
    converter_channel_select == 5'h08 |-> converter_in_valid && converter_pin_level == port_d_in[3])
    else $error("converter channel 8 not routed to port D bit 3");
endmodule

// >>> sim/pin_model.sv
`timescale 1ns/100ps
module pin_model
  import gpio_port_pkg::*;
(
  input  wire logic                 pclk,  // bus clock
  input  wire gpio_port_pkg::port_t a_out, // port A drive value
  input  wire gpio_port_pkg::port_t a_oe,  // port A driver enable
  input  wire gpio_port_pkg::port_t a_pu,  // port A pull-up connect
  input  wire gpio_port_pkg::port_t b_out, // port B drive value
  input  wire gpio_port_pkg::port_t b_oe,  // port B driver enable
  input  wire gpio_port_pkg::port_t d_out, // port D drive value
  input  wire gpio_port_pkg::port_t d_oe,  // port D driver enable
  input  wire gpio_port_pkg::port_t ext_a, // outside drive on port A
  input  wire gpio_port_pkg::port_t ext_b, // outside drive on port B
  input  wire gpio_port_pkg::port_t ext_d, // outside drive on port D
  input  wire gpio_port_pkg::port_t en_a,  // which port A pins are driven outside
  output gpio_port_pkg::port_t      a_pin, // port A wire level
  output gpio_port_pkg::port_t      b_pin, // port B wire level
  output gpio_port_pkg::port_t      d_pin  // port D wire level
);
  import gpio_port_pkg::*;
  port_t flt_q;
  port_t flt_d;
  // a floating pin wanders every cycle so a stale value never passes for a match
  always_comb flt_d = (flt_q === 8'hA5) ? 8'h5A : 8'hA5;
  always_ff @(posedge pclk) flt_q <= flt_d;
  // device driver wins, then outside driver, then pull-up, else floating
  function automatic port_t lvl(port_t o, port_t oe, port_t x, port_t en, port_t pu, port_t f);
    return (oe & o) | (~oe & en & x) | (~oe & ~en & pu) | (~oe & ~en & ~pu & f);
  endfunction
  assign a_pin = lvl(a_out, a_oe, ext_a, en_a, a_pu, flt_q);
  assign b_pin = lvl(b_out, b_oe, ext_b, 8'hFF, 8'h00, flt_q);
  assign d_pin = lvl(d_out, d_oe, ext_d, 8'hFF, 8'h00, flt_q);
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`include "gpio_port_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb_top;
  import gpio_port_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ser_en, ser_tx, rx, tw_en, scl_oe, sda_oe, scl_in, sda_in;
  logic        rc_en, cv_valid, cv_lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0]  t_act, t_out, t_oe, t_in;
  chan_t       chan;
  port_t       a_out, a_oe, a_pu, b_out, b_oe, d_out, d_oe, a_pin, b_pin, d_pin, en_a, pv;
  port_t       l[3], m[3], ext[3];
  logic [32:0] expq[$];
  logic [32:0] e;
  int          num_errors, samples_checked, p, c;
  logic [7:0]  li[3] = '{`IDX_PORT_A_LATCH, `IDX_PORT_B_LATCH, `IDX_PORT_D_LATCH};
  logic [7:0]  di[3] = '{`IDX_PORT_A_DIR, `IDX_PORT_B_DIR, `IDX_PORT_D_DIR};
  logic [7:0]  ri[5] = '{`IDX_PORT_A_DIR, `IDX_PORT_B_DIR, `IDX_PORT_D_DIR,
                         `IDX_PORT_A_PUE, `IDX_PIN_CONFIG};
  logic [7:0]  cfgs[3] = '{8'h02, 8'h03, 8'h01};
  logic        rcx[3] = '{1'b1, 1'b0, 1'b0};

  bidirectional_port_set dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_in(a_pin), .port_a_out(a_out), .port_a_oe(a_oe),
    .port_a_pullup(a_pu), .rc_clock_output_en(rc_en), .port_b_in(b_pin), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_d_in(d_pin), .port_d_out(d_out), .port_d_oe(d_oe),
    .serial_iface_enable(ser_en), .serial_tx_data(ser_tx), .serial_rx_data(rx),
    .twowire_enable(tw_en), .twowire_scl_oe(scl_oe), .twowire_sda_oe(sda_oe),
    .twowire_scl_in(scl_in), .twowire_sda_in(sda_in), .timer_ch_active(t_act),
    .timer_ch_out(t_out), .timer_ch_oe(t_oe), .timer_ch_in(t_in),
    .converter_channel_select(chan), .converter_in_valid(cv_valid), .converter_pin_level(cv_lvl));
  pin_model pins (.pclk(pclk), .a_out(a_out), .a_oe(a_oe), .a_pu(a_pu), .b_out(b_out),
    .b_oe(b_oe), .d_out(d_out), .d_oe(d_oe), .ext_a(ext[0]), .ext_b(ext[1]), .ext_d(ext[2]),
    .en_a(en_a), .a_pin(a_pin), .b_pin(b_pin), .d_pin(d_pin));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; an idle edge first so psel is never set twice in a step
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input port_t d);
    xfer(idx, 1'b1, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [32:0] x);
    expq.push_back(x);
    xfer(idx, 1'b0, 32'h0);
  endtask
  // read data and error flag are taken at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      `CHK("rdata", e, {pslverr, prdata})
    end
  end

  initial begin
    {psel, penable, pwrite, ser_en, ser_tx, tw_en, scl_oe, sda_oe} = '0;
    {t_act, t_out, t_oe, chan, paddr, pwdata} = '0;
    ext = '{8'h00, 8'h00, 8'h00};
    en_a = 8'hFF;
    seed = 32'd13665;
    num_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ri[i]) rd(ri[i], 33'h0);
    rd(8'h02, {1'b1, 32'h0});
    wr(`IDX_PIN_CONFIG, 8'h03);
    repeat (4) begin
      for (p = 0; p < 3; p++) begin
        l[p] = 8'(rnd());
        m[p] = (p == 0) ? (8'(rnd()) | 8'h80) : 8'(rnd());
        ext[p] <= 8'(rnd());
        wr(li[p], l[p]);
        wr(di[p], m[p]);
      end
      @(negedge pclk);
      `CHK("a_oe", m[0], a_oe)
      `CHK("b_oe", m[1], b_oe)
      for (p = 0; p < 3; p++) begin
        rd(li[p], {25'h0, (l[p] & m[p]) | (ext[p] & ~m[p])});
        rd(di[p], {25'h0, m[p]});
      end
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("lat", {l[0], l[1], l[2]}, {a_out, b_out, d_out})
    `CHK("oe", 24'h0, {a_oe, b_oe, d_oe})
    wr(`IDX_PIN_CONFIG, 8'h03);
    pv = 8'(rnd());
    wr(`IDX_PORT_A_PUE, pv);
    rd(`IDX_PORT_A_PUE, {25'h0, pv});
    wr(di[0], m[0]);
    @(negedge pclk);
    `CHK("pullup", pv & ~m[0], a_pu)
    wr(`IDX_PORT_A_PUE, 8'hFF);
    en_a <= 8'h00;
    rd(li[0], {25'h0, (l[0] & m[0]) | ~m[0]});
    en_a <= 8'hFF;
    for (p = 0; p < 3; p++) begin
      wr(`IDX_PIN_CONFIG, cfgs[p]);
      @(negedge pclk);
      `CHK("rc_en", rcx[p], rc_en)
    end
    `CHK("crystal_option", 2'b00, {a_oe[6], a_pu[6]})
    wr(di[1], 8'h00);
    wr(di[2], 8'h00);
    wr(`IDX_PIN_CONFIG, 8'h04);
    @(posedge pclk);
    {ser_en, tw_en, scl_oe, sda_oe, t_act} <= 6'h3F;
    {ser_tx, t_oe, t_out} <= 5'(rnd());
    @(negedge pclk);
    `CHK("ser", {2'b01, ser_tx, ext[2][7]}, {d_oe[7:6], d_out[6], rx})
    `CHK("tmr", {t_oe, (t_oe & t_out) | (~t_oe & ext[2][5:4])}, {d_oe[5:4], t_in})
    @(posedge pclk);
    ser_en <= 1'b0;
    {scl_oe, sda_oe} <= 2'(rnd());
    @(negedge pclk);
    `CHK("tw", {sda_oe, scl_oe, ~sda_oe & ext[2][7]}, {d_oe[7:6], sda_in})
    for (c = 0; c < 13; c++) begin
      @(posedge pclk);
      chan <= c[4:0];
      @(negedge pclk);
      `CHK("cv_valid", c < 12, cv_valid)
      if (c < 12) `CHK("cv_lvl", (c < 8) ? ext[1][c] : ext[2][11 - c], cv_lvl)
    end
    `CHK("queue", 0, expq.size())
    end_sim();
  end
endmodule
